// ---- pkg/mfr_cmd_map.svh ----
// Command codes, reset values and timing constants of the maker command space.
`ifndef MFR_CMD_MAP_SVH
`define MFR_CMD_MAP_SVH
`define C_CLEAR_FAULTS 8'h03
`define C_STORE_ALL    8'h15
`define C_RESTORE_ALL  8'h16
`define C_STATUS_COMM  8'h7e
`define C_PWM_CFG      8'hd4
`define C_ALARM_RESP   8'hd5
`define C_OT_RESP      8'hd6
`define C_IOUT_PK      8'hd7
`define C_ADC_SEL      8'hd8
`define C_VOFF         8'hda
`define C_RETRY        8'hdb
`define C_RESTART      8'hdc
`define C_VOUT_PK      8'hdd
`define C_VIN_PK       8'hde
`define C_TEXT_PK      8'hdf
`define C_IIN_PK       8'he1
`define C_CLR_PEAKS    8'he3
`define C_ICHIP        8'he4
`define C_PADS         8'he5
`define C_BUS_ADDR     8'he6
`define C_SPECIAL      8'he7
`define C_IIN_CAL      8'he8
`define C_LOG_STORE    8'hea
`define C_LOG_ERASE    8'hec
`define C_LOG_READ     8'hee
`define C_COMMON       8'hef
`define C_COMPARE      8'hf0
`define C_TDIE_PK      8'hf4
`define C_PHASE_CFG    8'hf5
`define C_TEMPCO       8'hf6
`define C_RVIN         8'hf7
`define C_TGAIN        8'hf8
`define C_TOFFSET      8'hf9
`define C_RAIL_ADDR    8'hfa
`define C_SOFT_RESET   8'hfd
`define R_PWM_CFG      8'hc1
`define R_ALARM_RESP   8'hc0
`define R_OT_RESP      8'hc0
`define R_ADC_SEL      8'h00
`define R_VOFF         16'h019a
`define R_RETRY        16'hfabc
`define R_RESTART      16'hfbe8
`define R_BUS_ADDR     8'h4f
`define R_IIN_CAL      16'hca80
`define R_PHASE_CFG    8'h10
`define R_TEMPCO       16'h0f3c
`define R_RVIN         16'h0be8
`define R_TGAIN        16'h4000
`define R_TOFFSET      16'h8000
`define R_RAIL_ADDR    8'h80
`define CML_WR_BAD_BIT 6
`define MS_NS          1000000
`define CLK_NS         8
`endif

// ---- pkg/mfr_cmd_pkg.sv ----
// Types shared by the maker command space.
package mfr_cmd_pkg;
`include "mfr_cmd_map.svh"
   typedef enum logic [1:0] {K_SEND, K_WRITE, K_READ, K_IDLE} cmd_kind_t;
   typedef enum logic [2:0] {T_VOUT, T_IOUT, T_VIN, T_IIN, T_TEXT, T_TDIE, T_ICHIP, T_NONE}
      tel_sel_t;
   typedef struct packed {
      logic [1:0][7:0]  pwm;
      logic [1:0][7:0]  alarm_resp;
      logic [1:0][15:0] voff;
      logic [1:0][15:0] retry;
      logic [1:0][15:0] restart;
      logic [7:0]       bus_addr;
      logic [15:0]      iin_cal;
      logic [7:0]       phase;
      logic [1:0][15:0] tempco;
      logic [15:0]      rvin;
      logic [1:0][15:0] tgain;
      logic [1:0][15:0] toffset;
      logic [1:0][7:0]  rail;
   } cfg_t;
   function automatic cfg_t cfg_default();
      cfg_t c;
      c.pwm        = {2{`R_PWM_CFG}};
      c.alarm_resp = {2{`R_ALARM_RESP}};
      c.voff       = {2{`R_VOFF}};
      c.retry      = {2{`R_RETRY}};
      c.restart    = {2{`R_RESTART}};
      c.bus_addr   = `R_BUS_ADDR;
      c.iin_cal    = `R_IIN_CAL;
      c.phase      = `R_PHASE_CFG;
      c.tempco     = {2{`R_TEMPCO}};
      c.rvin       = `R_RVIN;
      c.tgain      = {2{`R_TGAIN}};
      c.toffset    = {2{`R_TOFFSET}};
      c.rail       = {2{`R_RAIL_ADDR}};
      return c;
   endfunction
endpackage

// ---- core/mfr_cmd_space.sv ----
// Maker command space: configuration, peak telemetry, fault log, NVM and timers.
`timescale 1ns/10ps
// Contract
// - Per channel keep peak output current and voltage; read-only words.
// - Keep peak input voltage and input current; non-paged read-only words.
// - Keep peak external temperature per channel and peak die temperature.
// - Peak-clear send byte empties every stored peak.
// - Fast ADC select byte, default zero, never saved to NVM.
// - In sequenced off keep modulator on until output voltage below threshold.
// - Wait programmed retry interval in ms before each retry.
// - Hold run pin low at least the programmed restart delay in ms.
// - Take per-channel configured action when shared alarm pin goes low.
// - Report overtemperature action as read-only byte 0xc0.
// - Answer on 7-bit bus address from NVM-backed byte, default 0x4f.
// - Also answer on rail address, default 0x80.
// - Log-store send byte copies RAM fault log into NVM.
// - Log-clear send byte initialises the NVM log region.
// - Fault log is returned by block read.
// - Compare send byte checks working commands against NVM copy.
// - Reset send byte performs full reset without power cycle.
// - Store-all saves, restore-all reloads NVM-flagged commands only.
// - Reading unlisted codes does not disturb operation.
// - Writing an unlisted or read-only code sets status bit 6.
// - Return read-only special code word and pad state word.
// - Linear words: 5-bit signed exponent, 11-bit signed mantissa.
// - Output voltage words: unsigned, fixed exponent -12.
module mfr_cmd_space
   import mfr_cmd_pkg::*;
#(
   parameter int          LOG_DEPTH    = 16,
   parameter int          MS_CYCLES    = `MS_NS / `CLK_NS,
   parameter logic [15:0] SPECIAL_CODE = 16'h5a5a // Arbitrary value.
)(
   input  wire logic        SYS_CLK,
   input  wire logic        ARST_N,
   input  wire logic        CE,
   input  wire logic        CMD_VALID,
   input  wire logic [1:0]  CMD_KIND,
   input  wire logic [7:0]  CMD_CODE,
   input  wire logic        CMD_PAGE,
   input  wire logic [15:0] CMD_WDATA,
   input  wire logic [7:0]  CMD_BIDX,
   output logic             RD_VALID,
   output logic [15:0]      RD_DATA,
   input  wire logic [6:0]  ADDR_CHECK,
   output logic             ADDR_HIT,
   input  wire logic        TEL_VALID,
   input  wire logic [2:0]  TEL_SEL,
   input  wire logic        TEL_CHAN,
   input  wire logic [15:0] TEL_DATA,
   output logic [7:0]       ADC_FAST_SEL,
   input  wire logic        LOG_WR,
   input  wire logic [7:0]  LOG_BYTE,
   input  wire logic        ALARM_N_I,
   output logic [1:0]       ALARM_ACT,
   output logic [15:0]      ALARM_RESP,
   input  wire logic [1:0]  FAULT_OFF,
   output logic [1:0]       RETRY_GO,
   input  wire logic [1:0]  RUN_PULL,
   input  wire logic [1:0]  RUN_I,
   output logic [1:0]       RUN_O,
   output logic [1:0]       RUN_OE_N,
   input  wire logic [1:0]  SEQ_OFF,
   output logic [1:0]       MOD_ENABLE,
   output logic [7:0]       CML_STATUS,
   output logic             NVM_MISMATCH
);
   localparam int MSW = $clog2(MS_CYCLES + 1);

   typedef struct packed {
      cfg_t                        cfg;
      cfg_t                        nvm;
      logic [7:0]                  adc_sel;
      logic [1:0][15:0]            ipk;
      logic [1:0][15:0]            vpk;
      logic [1:0][15:0]            tpk;
      logic [1:0][15:0]            vlast;
      logic [15:0]                 vinpk;
      logic [15:0]                 iinpk;
      logic [15:0]                 diepk;
      logic [15:0]                 ichip;
      logic [8:0]                  pk_vld;
      logic [7:0]                  comm_memory_logic_status;
      logic                        mismatch;
      logic [LOG_DEPTH-1:0][7:0]   lram;
      logic [LOG_DEPTH-1:0][7:0]   lnvm;
      logic [1:0][15:0]            rty_cnt;
      logic [1:0][15:0]            rst_cnt;
      logic [1:0]                  rty_run;
      logic [1:0]                  run_low;
      logic [MSW-1:0]              ms_div;
      logic                        alarm_q;
      logic [1:0]                  alarm_act;
      logic [1:0]                  retry_go;
      logic [1:0]                  mod_en;
      logic                        rd_valid;
      logic [15:0]                 rd_data;
   } state_t;

   // *****************************************************************
   // Reset release and helper functions
   // *****************************************************************
   logic [1:0] rst_sync;
   logic       rst_n;
   state_t     s_reg;
   state_t     s_next;
   logic       tick;

   always_ff @(posedge SYS_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   function automatic state_t state_init();
      state_t r;
      r         = '0;
      r.cfg     = cfg_default();
      r.nvm     = cfg_default();
      r.adc_sel = `R_ADC_SEL;
      r.alarm_q = 1'b1;
      return r;
   endfunction
   localparam state_t S_INIT = state_init();

   // Decoded value of an exponent/mantissa word, scaled by 2^16.
   function automatic logic signed [47:0] lin_val(input logic [15:0] w);
      logic [4:0] sh;
      sh = w[15:11] + 5'd16;
      return $signed({{37{w[10]}}, w[10:0]}) <<< sh;
   endfunction

   // Whole milliseconds of a positive linear word, clipped to 16 bits.
   function automatic logic [15:0] lin_ms(input logic [15:0] w);
      logic signed [47:0] v;
      v = lin_val(w) >>> 16;
      if (v < 0)
         return 16'h0000;
      else if (v > 48'sd65535)
         return 16'hffff;
      return v[15:0];
   endfunction

   function automatic logic peak_take(input logic [15:0] nw, input logic [15:0] old,
                                      input logic vld, input logic unsig);
      if (!vld)
         return 1'b1;
      if (unsig)
         return nw > old;
      return lin_val(nw) > lin_val(old);
   endfunction

   // *****************************************************************
   // Next-state logic
   // *****************************************************************
   always_comb
   begin
      logic       ch;
      logic       wr;
      logic       rd;
      logic       sd;
      logic [7:0] bi;
      s_next = s_reg;
      ch     = CMD_PAGE;
      wr     = CMD_VALID && CMD_KIND == K_WRITE;
      rd     = CMD_VALID && CMD_KIND == K_READ;
      sd     = CMD_VALID && CMD_KIND == K_SEND;
      bi     = CMD_BIDX - 8'd1;
      s_next.rd_valid  = rd;
      s_next.alarm_act = 2'b00;
      s_next.retry_go  = 2'b00;
      s_next.alarm_q   = ALARM_N_I;
      tick             = s_reg.ms_div == MSW'(MS_CYCLES - 1);
      s_next.ms_div    = tick ? '0 : s_reg.ms_div + MSW'(1);

      // Telemetry peaks, cleared state loads the first fresh sample.
      if (TEL_VALID)
      begin
         unique case (tel_sel_t'(TEL_SEL))
            T_VOUT:
            begin
               s_next.vlast[TEL_CHAN] = TEL_DATA;
               if (peak_take(TEL_DATA, s_reg.vpk[TEL_CHAN], s_reg.pk_vld[{2'd1, TEL_CHAN}],
                             1'b1))
               begin
                  s_next.vpk[TEL_CHAN] = TEL_DATA;
                  s_next.pk_vld[{2'd1, TEL_CHAN}] = 1'b1;
               end
            end
            T_IOUT:
               if (peak_take(TEL_DATA, s_reg.ipk[TEL_CHAN], s_reg.pk_vld[{2'd0, TEL_CHAN}],
                             1'b0))
               begin
                  s_next.ipk[TEL_CHAN] = TEL_DATA;
                  s_next.pk_vld[{2'd0, TEL_CHAN}] = 1'b1;
               end
            T_TEXT:
               if (peak_take(TEL_DATA, s_reg.tpk[TEL_CHAN], s_reg.pk_vld[{2'd2, TEL_CHAN}],
                             1'b0))
               begin
                  s_next.tpk[TEL_CHAN] = TEL_DATA;
                  s_next.pk_vld[{2'd2, TEL_CHAN}] = 1'b1;
               end
            T_VIN:
               if (peak_take(TEL_DATA, s_reg.vinpk, s_reg.pk_vld[6], 1'b0))
               begin
                  s_next.vinpk = TEL_DATA;
                  s_next.pk_vld[6] = 1'b1;
               end
            T_IIN:
               if (peak_take(TEL_DATA, s_reg.iinpk, s_reg.pk_vld[7], 1'b0))
               begin
                  s_next.iinpk = TEL_DATA;
                  s_next.pk_vld[7] = 1'b1;
               end
            T_TDIE:
               if (peak_take(TEL_DATA, s_reg.diepk, s_reg.pk_vld[8], 1'b0))
               begin
                  s_next.diepk = TEL_DATA;
                  s_next.pk_vld[8] = 1'b1;
               end
            T_ICHIP:
               s_next.ichip = TEL_DATA;
            default:
               s_next.ichip = s_reg.ichip;
         endcase
      end

      if (LOG_WR)
         s_next.lram = {s_reg.lram[LOG_DEPTH-2:0], LOG_BYTE};

      // Alarm pin, retry and restart timers per channel.
      for (int c = 0; c < 2; c++)
      begin
         if (s_reg.alarm_q && !ALARM_N_I)
            s_next.alarm_act[c] = 1'b1;
         if (FAULT_OFF[c])
         begin
            s_next.rty_run[c] = 1'b1;
            s_next.rty_cnt[c] = lin_ms(s_reg.cfg.retry[c]);
         end
         else if (s_reg.rty_run[c] && tick)
         begin
            if (s_reg.rty_cnt[c] == 16'h0000)
            begin
               s_next.rty_run[c]  = 1'b0;
               s_next.retry_go[c] = 1'b1;
            end
            else
               s_next.rty_cnt[c] = s_reg.rty_cnt[c] - 16'd1;
         end
         if (RUN_PULL[c] && !s_reg.run_low[c])
         begin
            s_next.run_low[c] = 1'b1;
            s_next.rst_cnt[c] = lin_ms(s_reg.cfg.restart[c]);
         end
         else if (s_reg.run_low[c])
         begin
            if (s_reg.rst_cnt[c] != 16'h0000)
               s_next.rst_cnt[c] = tick ? s_reg.rst_cnt[c] - 16'd1 : s_reg.rst_cnt[c];
            // Releasing only on a tick keeps the pin low for the whole count.
            else if (!RUN_PULL[c] && tick)
               s_next.run_low[c] = 1'b0;
         end
         s_next.mod_en[c] = !SEQ_OFF[c] || s_reg.vlast[c] > s_reg.cfg.voff[c];
      end

      // Register reads; unlisted codes read as zero without side effects.
      s_next.rd_data = 16'h0000;
      if (rd)
      begin
         unique case (CMD_CODE)
            `C_PWM_CFG:    s_next.rd_data = {8'h00, s_reg.cfg.pwm[ch]};
            `C_ALARM_RESP: s_next.rd_data = {8'h00, s_reg.cfg.alarm_resp[ch]};
            `C_OT_RESP:    s_next.rd_data = {8'h00, `R_OT_RESP};
            `C_IOUT_PK:    s_next.rd_data = s_reg.ipk[ch];
            `C_ADC_SEL:    s_next.rd_data = {8'h00, s_reg.adc_sel};
            `C_VOFF:       s_next.rd_data = s_reg.cfg.voff[ch];
            `C_RETRY:      s_next.rd_data = s_reg.cfg.retry[ch];
            `C_RESTART:    s_next.rd_data = s_reg.cfg.restart[ch];
            `C_VOUT_PK:    s_next.rd_data = s_reg.vpk[ch];
            `C_VIN_PK:     s_next.rd_data = s_reg.vinpk;
            `C_TEXT_PK:    s_next.rd_data = s_reg.tpk[ch];
            `C_IIN_PK:     s_next.rd_data = s_reg.iinpk;
            `C_ICHIP:      s_next.rd_data = s_reg.ichip;
            `C_PADS:       s_next.rd_data = {11'h000, ALARM_N_I, RUN_I, s_reg.run_low};
            `C_BUS_ADDR:   s_next.rd_data = {8'h00, s_reg.cfg.bus_addr};
            `C_SPECIAL:    s_next.rd_data = SPECIAL_CODE;
            `C_IIN_CAL:    s_next.rd_data = s_reg.cfg.iin_cal;
            `C_LOG_READ:   s_next.rd_data = CMD_BIDX == 8'h00 ? 16'(LOG_DEPTH) :
                              (32'(bi) < LOG_DEPTH ? {8'h00, s_reg.lnvm[bi]} : 16'h0000);
            `C_COMMON:     s_next.rd_data = {15'h0000, s_reg.mismatch};
            `C_STATUS_COMM: s_next.rd_data = {8'h00, s_reg.comm_memory_logic_status};
            `C_TDIE_PK:    s_next.rd_data = s_reg.diepk;
            `C_PHASE_CFG:  s_next.rd_data = {8'h00, s_reg.cfg.phase};
            `C_TEMPCO:     s_next.rd_data = s_reg.cfg.tempco[ch];
            `C_RVIN:       s_next.rd_data = s_reg.cfg.rvin;
            `C_TGAIN:      s_next.rd_data = s_reg.cfg.tgain[ch];
            `C_TOFFSET:    s_next.rd_data = s_reg.cfg.toffset[ch];
            `C_RAIL_ADDR:  s_next.rd_data = {8'h00, s_reg.cfg.rail[ch]};
            default:       s_next.rd_data = 16'h0000;
         endcase
      end

      // Register writes; anything not writable flags a memory/logic fault.
      if (wr)
      begin
         unique case (CMD_CODE)
            `C_PWM_CFG:    s_next.cfg.pwm[ch] = CMD_WDATA[7:0];
            `C_ALARM_RESP: s_next.cfg.alarm_resp[ch] = CMD_WDATA[7:0];
            `C_ADC_SEL:    s_next.adc_sel = CMD_WDATA[7:0];
            `C_VOFF:       s_next.cfg.voff[ch] = CMD_WDATA;
            `C_RETRY:      s_next.cfg.retry[ch] = CMD_WDATA;
            `C_RESTART:    s_next.cfg.restart[ch] = CMD_WDATA;
            `C_BUS_ADDR:   s_next.cfg.bus_addr = CMD_WDATA[7:0];
            `C_IIN_CAL:    s_next.cfg.iin_cal = CMD_WDATA;
            `C_PHASE_CFG:  s_next.cfg.phase = CMD_WDATA[7:0];
            `C_TEMPCO:     s_next.cfg.tempco[ch] = CMD_WDATA;
            `C_RVIN:       s_next.cfg.rvin = CMD_WDATA;
            `C_TGAIN:      s_next.cfg.tgain[ch] = CMD_WDATA;
            `C_TOFFSET:    s_next.cfg.toffset[ch] = CMD_WDATA;
            `C_RAIL_ADDR:  s_next.cfg.rail[ch] = CMD_WDATA[7:0];
            default:       s_next.comm_memory_logic_status[`CML_WR_BAD_BIT] = 1'b1;
         endcase
      end

      // Send-byte commands.
      if (sd)
      begin
         unique case (CMD_CODE)
            `C_CLEAR_FAULTS: s_next.comm_memory_logic_status = 8'h00;
            `C_CLR_PEAKS:    s_next.pk_vld = '0;
            `C_LOG_STORE:    s_next.lnvm = s_reg.lram;
            `C_LOG_ERASE:    s_next.lnvm = '1;
            `C_COMPARE:      s_next.mismatch = s_reg.cfg != s_reg.nvm;
            `C_STORE_ALL:    s_next.nvm = s_reg.cfg;
            `C_RESTORE_ALL:  s_next.cfg = s_reg.nvm;
            `C_SOFT_RESET:
            begin
               s_next      = state_init();
               s_next.nvm  = s_reg.nvm;
               s_next.cfg  = s_reg.nvm;
               s_next.lnvm = s_reg.lnvm;
            end
            default:         s_next.comm_memory_logic_status[`CML_WR_BAD_BIT] = 1'b1;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= S_INIT;
      else if (CE)
         s_reg <= s_next;
   end

   // *****************************************************************
   // Outputs
   // *****************************************************************
   assign RD_VALID     = s_reg.rd_valid;
   assign RD_DATA      = s_reg.rd_data;
   assign ADDR_HIT     = ADDR_CHECK == s_reg.cfg.bus_addr[6:0] ||
                         (!s_reg.cfg.rail[0][7] && ADDR_CHECK == s_reg.cfg.rail[0][6:0]) ||
                         (!s_reg.cfg.rail[1][7] && ADDR_CHECK == s_reg.cfg.rail[1][6:0]);
   assign ADC_FAST_SEL = s_reg.adc_sel;
   assign ALARM_ACT    = s_reg.alarm_act;
   assign ALARM_RESP   = s_reg.cfg.alarm_resp;
   assign RETRY_GO     = s_reg.retry_go;
   assign RUN_O        = 2'b00;
   assign RUN_OE_N     = ~s_reg.run_low;
   assign MOD_ENABLE   = s_reg.mod_en;
   assign CML_STATUS   = s_reg.comm_memory_logic_status;
   assign NVM_MISMATCH = s_reg.mismatch;

   // *****************************************************************
   // Assertions
   // *****************************************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_send(logic [7:0] code);
      CE && CMD_VALID && CMD_KIND == K_SEND && CMD_CODE == code;
   endsequence

   a_peak_clear: assert property (s_send(`C_CLR_PEAKS) |=> s_reg.pk_vld == '0)
      else $error("peaks not emptied by clear");
   a_read_answer: assert property (CE && CMD_VALID && CMD_KIND == K_READ |=> RD_VALID)
      else $error("read not answered next cycle");
   a_ro_write: assert property (CE && CMD_VALID && CMD_KIND == K_WRITE &&
                                CMD_CODE == `C_OT_RESP |=> CML_STATUS[6])
      else $error("write to read-only code not flagged");
   a_store_compare: assert property (s_send(`C_STORE_ALL) ##1 s_send(`C_COMPARE)
                                     |=> !NVM_MISMATCH)
      else $error("compare after store shows mismatch");
   a_store_gap: assert property (s_send(`C_STORE_ALL) ##1 !(CE && CMD_VALID)
                                 ##1 s_send(`C_COMPARE) |=> !NVM_MISMATCH)
      else $error("compare after spaced store shows mismatch");
   a_soft_reset: assert property (s_send(`C_SOFT_RESET) |=>
                                  s_reg.cfg == $past(s_reg.nvm) && CML_STATUS == 8'h00)
      else $error("soft reset did not reload saved set");
   a_run_hold: assert property (!RUN_OE_N[0] && s_reg.rst_cnt[0] != 16'h0000 |=>
                                !RUN_OE_N[0])
      else $error("run pin released before restart delay");
   a_retry_wait: assert property (RETRY_GO[0] |-> $past(s_reg.rty_run[0]) &&
                                  $past(s_reg.rty_cnt[0]) == 16'h0000)
      else $error("retry issued before interval ran out");
   a_alarm_act: assert property (CE && s_reg.alarm_q && !ALARM_N_I |=> ALARM_ACT == 2'b11)
      else $error("alarm pin edge not acted on");
   a_addr_write: assert property (CE && CMD_VALID && CMD_KIND == K_WRITE &&
                                  CMD_CODE == `C_BUS_ADDR ##1 ADDR_CHECK == $past(CMD_WDATA[6:0])
                                  |-> ADDR_HIT)
      else $error("new bus address not answered");
   a_vin_peak: assert property (s_reg.pk_vld[6] &&
                                !(CE && CMD_VALID && CMD_KIND == K_SEND) |=>
                                lin_val(s_reg.vinpk) >= lin_val($past(s_reg.vinpk)))
      else $error("input voltage peak decreased");
   a_mod_hold: assert property (SEQ_OFF[0] && s_reg.vlast[0] > s_reg.cfg.voff[0] && CE
                                |=> MOD_ENABLE[0])
      else $error("modulator stopped above threshold");
endmodule

// ---- bench/host_model.sv ----
// Host model that issues command transactions to the maker command space.
`timescale 1ns/10ps
module host_model (
   input  wire logic        clk,
   output logic             valid,
   output logic [1:0]       kind,
   output logic [7:0]       code,
   output logic             page,
   output logic [15:0]      wdata,
   output logic [7:0]       bidx,
   input  wire logic        rd_valid,
   input  wire logic [15:0] rd_data
);
   initial {valid, kind, code, page, wdata, bidx} = {1'b0, 2'h3, 8'h00, 1'b0, 16'h0000, 8'h00};
   // Holds a request for one edge, then drops valid, drives kind idle and toggles the other released lines.
   task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [15:0] w,
                       input logic [7:0] b, output logic [15:0] r);
      @(negedge clk);
      {valid, kind, code, page, wdata, bidx} = {1'b1, k, c, 1'b0, w, b};
      @(negedge clk);
      r = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
      {valid, kind, code, page, wdata, bidx} = {1'b0, 2'h3, ~c, 1'b1, ~w, ~b};
   endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking testbench of the maker command space.
`timescale 1ns/10ps
module testbench;
   import mfr_cmd_pkg::*;
   localparam logic [1:0] snd = 2'd0, wr = 2'd1, rd = 2'd2;
   logic        clk = 0, arst_n = 0, alarm_n = 1, tel_v = 0, log_wr = 0, v, pg, rv, hit, mis;
   logic [1:0]  f_off = 0, run_pull = 0, seq_off = 0, run_oe_n, run_o, act, go, k, mod_en;
   logic [2:0]  tel_sel = 0;
   logic [6:0]  adr = 7'h4f;
   logic [7:0]  log_b = 8'h00, comm_memory_logic_status, c, bi, adc;
   logic [15:0] tel_d = 16'h0000, rdd, d, wd, aresp;
   int          num_errors = 0, n_compared = 0, i, n;
   initial forever #4 clk = ~clk;
   host_model host (.clk(clk), .valid(v), .kind(k), .code(c), .page(pg), .wdata(wd),
      .bidx(bi), .rd_valid(rv), .rd_data(rdd));
   mfr_cmd_space #(.MS_CYCLES(4)) dut (.SYS_CLK(clk), .ARST_N(arst_n), .CE(1'b1),
      .CMD_VALID(v), .CMD_KIND(k), .CMD_CODE(c), .CMD_PAGE(pg), .CMD_WDATA(wd),
      .CMD_BIDX(bi), .RD_VALID(rv), .RD_DATA(rdd), .ADDR_CHECK(adr), .ADDR_HIT(hit),
      .TEL_VALID(tel_v), .TEL_SEL(tel_sel), .TEL_CHAN(1'b0), .TEL_DATA(tel_d),
      .ADC_FAST_SEL(adc), .LOG_WR(log_wr), .LOG_BYTE(log_b), .ALARM_N_I(alarm_n),
      .ALARM_ACT(act), .ALARM_RESP(aresp), .FAULT_OFF(f_off), .RETRY_GO(go),
      .RUN_PULL(run_pull), .RUN_I(run_oe_n | run_o), .RUN_O(run_o), .RUN_OE_N(run_oe_n),
      .SEQ_OFF(seq_off), .MOD_ENABLE(mod_en), .CML_STATUS(comm_memory_logic_status), .NVM_MISMATCH(mis));
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmd(input logic [1:0] kd, input logic [7:0] cd,
                      input logic [15:0] w = 16'h0000, input logic [7:0] b = 8'h00);
      host.xfer(kd, cd, w, b, d);
   endtask
   task automatic tel(input logic [2:0] s, input logic [15:0] w);
      @(negedge clk);
      {tel_v, tel_sel, tel_d} = {1'b1, s, w};
      @(negedge clk);
      {tel_v, tel_d} = {1'b0, ~w};
   endtask
   task automatic t_defaults;
      logic [7:0]  cd [8] = '{8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hda, 8'hdb, 8'hdc, 8'he6};
      logic [15:0] ex [8] = '{16'h00c1, 16'h00c0, 16'h00c0, 16'h0000, 16'h019a, 16'hfabc,
                              16'hfbe8, 16'h004f};
      for (i = 0; i < 8; i++)
      begin
         cmd(rd, cd[i]);
         chk("reset_value", d, ex[i]);
      end
      $display("defaults done");
   endtask
   task automatic t_peaks;
      cmd(snd, 8'he3);
      tel(3'd2, 16'hf81e);
      tel(3'd2, 16'h0010);
      tel(3'd2, 16'h000a);
      cmd(rd, 8'hde);
      chk("vin_peak", d, 16'h0010);
      cmd(snd, 8'he3);
      tel(3'd2, 16'h000a);
      tel(3'd1, 16'h0021);
      cmd(rd, 8'hde);
      chk("vin_cleared", d, 16'h000a);
      cmd(rd, 8'hd7);
      chk("iout_peak", d, 16'h0021);
      $display("peaks done");
   endtask
   task automatic t_bad_write;
      cmd(wr, 8'hd6, 16'h0055);
      chk("cml_bad", 16'(comm_memory_logic_status[6]), 16'h0001);
      cmd(rd, 8'hd6);
      chk("ro_kept", d, 16'h00c0);
      cmd(snd, 8'h03);
      chk("cml_clear", 16'(comm_memory_logic_status[6]), 16'h0000);
      cmd(wr, 8'hd5, 16'h0012);
      cmd(snd, 8'hfd);
      cmd(rd, 8'hd5);
      chk("soft_reset", d, 16'h00c0);
      chk("alarm_resp", aresp, 16'hc0c0);
      $display("bad write done");
   endtask
   task automatic t_addr;
      #1 chk("addr_hit", 16'(hit), 16'h0001);
      @(negedge clk) adr = 7'h4e;
      #1 chk("addr_miss", 16'(hit), 16'h0000);
      cmd(wr, 8'hfa, 16'h0022);
      adr = 7'h22;
      #1 chk("rail_hit", 16'(hit), 16'h0001);
      $display("address done");
   endtask
   task automatic t_events;
      n = 0;
      @(negedge clk) alarm_n = 0;
      repeat (6) @(negedge clk) n += (act === 2'b11);
      alarm_n = 1;
      chk("alarm_pulses", 16'(n), 16'h0001);
      cmd(wr, 8'hdb, 16'h0002);
      @(negedge clk) f_off = 2'b01;
      @(negedge clk) f_off = 2'b00;
      for (n = 1; n < 40 && go[0] !== 1'b1; n++) @(negedge clk);
      chk("retry_wait", 16'(n >= 8 && n < 20), 16'h0001);
      @(negedge clk) {log_wr, log_b} = {1'b1, 8'h5c};
      @(negedge clk) log_wr = 0;
      cmd(snd, 8'hea);
      cmd(rd, 8'hee, 16'h0000, 8'h00);
      chk("log_count", d, 16'h0010);
      cmd(rd, 8'hee, 16'h0000, 8'h01);
      chk("log_stored", d, 16'h005c);
      cmd(snd, 8'hec);
      cmd(rd, 8'hee, 16'h0000, 8'h01);
      chk("log_erased", d, 16'h00ff);
      $display("events done");
   endtask
   task automatic t_nvm_run;
      cmd(wr, 8'hd8, 16'h0003);
      chk("adc_sel", {8'h00, adc}, 16'h0003);
      cmd(snd, 8'h15);
      cmd(snd, 8'hf0);
      chk("cmp_same", 16'(mis), 16'h0000);
      adr = 7'h33;
      cmd(wr, 8'he6, 16'h0033);
      chk("addr_new", 16'(hit), 16'h0001);
      cmd(snd, 8'hf0);
      chk("cmp_diff", 16'(mis), 16'h0001);
      cmd(snd, 8'h16);
      cmd(rd, 8'he6);
      chk("restored", d, 16'h004f);
      cmd(wr, 8'hdc, 16'h0002);
      @(negedge clk) run_pull = 2'b01;
      @(negedge clk) run_pull = 2'b00;
      chk("run_pulled", {14'h0000, run_oe_n}, 16'h0002);
      for (n = 0; n < 40 && run_oe_n[0] === 1'b0; n++) @(negedge clk);
      chk("run_hold", 16'(n >= 8 && n < 13), 16'h0001);
      tel(3'd0, 16'h0200);
      @(negedge clk) seq_off = 2'b01;
      @(negedge clk) chk("mod_above", {14'h0000, mod_en}, 16'h0003);
      tel(3'd0, 16'h0100);
      @(negedge clk) chk("mod_below", {14'h0000, mod_en}, 16'h0002);
      seq_off = 2'b00;
      cmd(rd, 8'hdd);
      chk("vout_peak", d, 16'h0200);
      $display("nvm and pins done");
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge clk);
      arst_n = 1;
      repeat (3) @(negedge clk);
      t_defaults;
      t_peaks;
      t_bad_write;
      t_addr;
      t_events;
      t_nvm_run;
      print_verdict;
   end
endmodule
